// file: core/hltp_rx_parser.sv
`timescale 1ns/1ns

module hltp_rx_parser
   import hltp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic [15:0] station_id,
   output logic ev_enq,
   output logic ev_ack,
   output logic ev_eot,
   output logic ev_cmd,
   output logic [7:0] cmd_letter,
   output logic [7:0] cmd_arg,
   output logic ev_data,
   output logic [7:0] data_char
);

   hltp_parse_t ps_reg, ps_next;
   hltp_code_t kind_reg, kind_next;
   logic [7:0] letter_reg, letter_next;
   logic [7:0] arg_reg, arg_next;
   logic [7:0] data_reg, data_next;
   logic enq_reg, enq_next;
   logic ack_reg, ack_next;
   logic eot_reg, eot_next;
   logic cmd_reg, cmd_next;
   logic dat_reg, dat_next;
   logic fresh;

   always_comb begin
      ps_next = ps_reg;
      kind_next = kind_reg;
      letter_next = letter_reg;
      arg_next = arg_reg;
      data_next = data_reg;
      enq_next = 1'b0;
      ack_next = 1'b0;
      eot_next = 1'b0;
      cmd_next = 1'b0;
      dat_next = 1'b0;
      fresh = 1'b0;
      if (rx_valid) begin
         case (ps_reg)
            PS_IDLE: fresh = 1'b1;
            PS_D1: begin
               // Other stations' codes drop back to idle silently
               ps_next = (rx_char == station_id[15:8]) ? PS_D2 : PS_IDLE; // see (RL13)
            end
            PS_D2: begin
               ps_next = PS_IDLE;
               if (rx_char == station_id[7:0]) begin // see (RL13)
                  enq_next = (kind_reg == HLTP_K_ENQ);
                  ack_next = (kind_reg == HLTP_K_ACK);
                  eot_next = (kind_reg == HLTP_K_EOT);
                  if (kind_reg == HLTP_K_ACK) begin
                     ps_next = PS_CMD;
                  end
               end
            end
            PS_CMD: begin
               if (rx_char >= HLTP_CH_UPPER_A && rx_char <= HLTP_CH_UPPER_Z) begin
                  letter_next = rx_char;
                  arg_next = HLTP_ARG_NONE;
                  ps_next = PS_ARG;
               end else begin
                  fresh = 1'b1;
               end
            end
            PS_ARG: begin
               if (rx_char == HLTP_CH_CR) begin
                  ps_next = PS_LF;
               end else if (rx_char >= HLTP_CH_DIGIT_0 && rx_char <= HLTP_CH_DIGIT_9) begin
                  arg_next = rx_char;
               end else begin
                  ps_next = PS_IDLE;
               end
            end
            PS_LF: begin
               cmd_next = (rx_char == HLTP_CH_LF);
               ps_next = PS_IDLE;
            end
            default: ps_next = PS_IDLE;
         endcase
         if (fresh) begin
            ps_next = PS_D1;
            if (rx_char == HLTP_CH_ENQ) begin
               kind_next = HLTP_K_ENQ;
            end else if (rx_char == HLTP_CH_ACK) begin
               kind_next = HLTP_K_ACK;
            end else if (rx_char == HLTP_CH_EOT) begin
               kind_next = HLTP_K_EOT;
            end else begin
               ps_next = PS_IDLE;
               dat_next = 1'b1;
               data_next = rx_char;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ps_reg <= PS_IDLE;
         kind_reg <= HLTP_K_ENQ;
         letter_reg <= 8'h00;
         arg_reg <= 8'h00;
         data_reg <= 8'h00;
         enq_reg <= 1'b0;
         ack_reg <= 1'b0;
         eot_reg <= 1'b0;
         cmd_reg <= 1'b0;
         dat_reg <= 1'b0;
      end else begin
         ps_reg <= ps_next;
         kind_reg <= kind_next;
         letter_reg <= letter_next;
         arg_reg <= arg_next;
         data_reg <= data_next;
         enq_reg <= enq_next;
         ack_reg <= ack_next;
         eot_reg <= eot_next;
         cmd_reg <= cmd_next;
         dat_reg <= dat_next;
      end
   end

   assign ev_enq = enq_reg;
   assign ev_ack = ack_reg;
   assign ev_eot = eot_reg;
   assign ev_cmd = cmd_reg;
   assign cmd_letter = letter_reg;
   assign cmd_arg = arg_reg;
   assign ev_data = dat_reg;
   assign data_char = data_reg;

endmodule : hltp_rx_parser

// file: core/hltp_session.sv
`timescale 1ns/1ns

// Operation
// (RL1) Enquiry with station answered by acknowledge
// (RL2) Host selects identifier, then reads in second session
// (RL3) Host may read without selecting first
// (RL4) Select command, identifier, acknowledge, activate, end
// (RL5) Read command acknowledged, then program data sent
// (RL6) Host read ends: acknowledge, host acknowledge, host end
// (RL7) Own transmit ends: acknowledge, host acknowledge, send end
// (RL8) Message after readiness, at most 32 characters
// (RL9) Host message: command, text, acknowledge, host end
// (RL10) Own message: enquiry, command, text, end
// (RL11) Received message enters terminal mode unless locked out
// (RL12) Every message logged with its direction
// (RL13) Codes for other stations are ignored
module hltp_session
   import hltp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] station_id,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   output logic tx_valid,
   output logic [7:0] tx_char,
   input wire logic tx_ready,
   input wire logic src_valid,
   input wire logic [7:0] src_char,
   input wire logic src_last,
   output logic src_ready,
   input wire logic msg_send_req,
   input wire logic lockout,
   input wire logic term_exit,
   output logic term_mode,
   output logic rcv_valid,
   output logic [7:0] rcv_char,
   output logic [1:0] rcv_kind,
   output logic program_select,
   output logic read_start,
   output logic log_valid,
   output logic log_dir,
   output logic busy
);

   logic ev_enq;
   logic ev_ack;
   logic ev_eot;
   logic ev_cmd;
   logic [7:0] cmd_letter;
   logic [7:0] cmd_arg;
   logic ev_data;
   logic [7:0] data_char;

   hltp_rx_parser u_parser (
      .clk(clk),
      .rst_b(rst_b),
      .rx_valid(rx_valid),
      .rx_char(rx_char),
      .station_id(station_id),
      .ev_enq(ev_enq),
      .ev_ack(ev_ack),
      .ev_eot(ev_eot),
      .ev_cmd(ev_cmd),
      .cmd_letter(cmd_letter),
      .cmd_arg(cmd_arg),
      .ev_data(ev_data),
      .data_char(data_char)
   );

   hltp_state_t st_reg, st_next;
   logic [7:0] seq_buf_reg [HLTP_SEQ_DEPTH];
   logic [7:0] seq_buf_next [HLTP_SEQ_DEPTH];
   logic [2:0] seq_len_reg, seq_len_next;
   logic [2:0] seq_idx_reg, seq_idx_next;
   logic tx_valid_reg, tx_valid_next;
   logic [7:0] tx_char_reg, tx_char_next;
   logic [5:0] cnt_reg, cnt_next;
   logic term_reg, term_next;
   logic rcv_valid_reg, rcv_valid_next;
   logic [7:0] rcv_char_reg, rcv_char_next;
   logic [1:0] rcv_kind_reg, rcv_kind_next;
   logic select_reg, select_next;
   logic read_reg, read_next;
   logic log_valid_reg, log_valid_next;
   logic log_dir_reg, log_dir_next;
   logic tx_idle;
   logic code_go;
   logic [7:0] code_char;
   logic code_cmd;
   logic stream_end;

   assign tx_idle = !tx_valid_reg && (seq_idx_reg == seq_len_reg);

   always_comb begin
      st_next = st_reg;
      seq_buf_next = seq_buf_reg;
      seq_len_next = seq_len_reg;
      seq_idx_next = seq_idx_reg;
      tx_valid_next = tx_valid_reg;
      tx_char_next = tx_char_reg;
      cnt_next = cnt_reg;
      term_next = term_reg;
      rcv_valid_next = 1'b0;
      rcv_char_next = rcv_char_reg;
      rcv_kind_next = rcv_kind_reg;
      select_next = 1'b0;
      read_next = 1'b0;
      log_valid_next = 1'b0;
      log_dir_next = log_dir_reg;
      src_ready = 1'b0;
      code_go = 1'b0;
      code_char = HLTP_CH_ACK;
      code_cmd = 1'b0;
      stream_end = 1'b0;

      // Character sender; one idle cycle between characters keeps it simple
      if (tx_valid_reg && tx_ready) begin
         tx_valid_next = 1'b0;
      end else if (!tx_valid_reg && seq_idx_reg != seq_len_reg) begin
         tx_char_next = seq_buf_reg[seq_idx_reg];
         tx_valid_next = 1'b1;
         seq_idx_next = seq_idx_reg + 3'h1;
      end

      if (term_exit) begin
         term_next = 1'b0;
      end

      case (st_reg)
         ST_IDLE: begin
            // A host enquiry wins over a pending local message request
            if (ev_enq) begin
               code_go = 1'b1; // see (RL1)
               st_next = ST_WAIT_CMD;
            end else if (msg_send_req) begin
               code_go = 1'b1; // see (RL10)
               code_char = HLTP_CH_ENQ;
               st_next = ST_CI_LINK;
            end
         end
         ST_WAIT_CMD: begin
            cnt_next = 6'h00;
            if (ev_eot) begin
               st_next = ST_IDLE;
            end else if (ev_cmd) begin
               if (cmd_letter == HLTP_CMD_SELECT && cmd_arg == HLTP_ARG_ONE) begin
                  code_go = 1'b1; // see (RL4)
                  st_next = ST_RX_ID;
               end else if (cmd_letter == HLTP_CMD_READ && cmd_arg == HLTP_ARG_ONE) begin
                  // Data source serves the last selected or active program
                  code_go = 1'b1; // see (RL5), see (RL2), see (RL3)
                  read_next = 1'b1;
                  st_next = ST_TX_DATA;
               end else if (cmd_letter == HLTP_CMD_MSG) begin
                  code_go = 1'b1; // see (RL9), see (RL8)
                  st_next = ST_RX_MSG;
               end
            end
         end
         ST_RX_ID: begin
            if (ev_data) begin
               rcv_valid_next = 1'b1;
               rcv_char_next = data_char;
               rcv_kind_next = HLTP_RK_ID;
            end else if (ev_ack) begin
               code_go = 1'b1; // see (RL4)
               select_next = 1'b1;
               st_next = ST_WAIT_EOT;
            end
         end
         ST_RX_MSG: begin
            if (ev_data) begin
               // Text past the limit is dropped, not passed on
               if (cnt_reg != HLTP_MSG_MAX) begin // see (RL8)
                  rcv_valid_next = 1'b1;
                  rcv_char_next = data_char;
                  rcv_kind_next = HLTP_RK_MSG;
                  cnt_next = cnt_reg + 6'h01;
               end
            end else if (ev_ack) begin
               code_go = 1'b1; // see (RL9)
               log_valid_next = 1'b1; // see (RL12)
               log_dir_next = HLTP_LOG_FROM_HOST;
               if (!lockout) begin
                  term_next = 1'b1; // see (RL11)
               end
               st_next = ST_WAIT_EOT;
            end
         end
         ST_WAIT_EOT: begin
            if (ev_eot) begin
               st_next = ST_IDLE; // see (RL4), see (RL6), see (RL9)
            end
         end
         ST_TX_DATA: begin
            src_ready = tx_idle;
            if (src_valid && tx_idle) begin
               tx_char_next = src_char;
               tx_valid_next = 1'b1;
               if (src_last) begin
                  stream_end = 1'b1;
                  st_next = ST_H_RACK; // see (RL6)
               end
            end
         end
         ST_H_RACK: begin
            if (ev_ack) begin
               st_next = ST_WAIT_EOT; // see (RL6)
            end
         end
         ST_CI_LINK: begin
            if (ev_ack) begin
               code_go = 1'b1; // see (RL10)
               code_cmd = 1'b1;
               cnt_next = 6'h00;
               st_next = ST_CI_CMDACK;
            end
         end
         ST_CI_CMDACK: begin
            // Text waits for the host's readiness
            if (ev_ack) begin
               st_next = ST_CI_TEXT; // see (RL8)
            end
         end
         ST_CI_TEXT: begin
            src_ready = tx_idle;
            if (src_valid && tx_idle) begin
               // Over-long text is drained from the source but not sent
               if (cnt_reg != HLTP_MSG_MAX) begin // see (RL8)
                  tx_char_next = src_char;
                  tx_valid_next = 1'b1;
                  cnt_next = cnt_reg + 6'h01;
               end
               if (src_last) begin
                  stream_end = 1'b1;
                  st_next = ST_CI_RACK; // see (RL7)
               end
            end
         end
         ST_CI_RACK: begin
            if (ev_ack) begin
               code_go = 1'b1; // see (RL7), see (RL10)
               code_char = HLTP_CH_EOT;
               log_valid_next = 1'b1; // see (RL12)
               log_dir_next = HLTP_LOG_TO_HOST;
               st_next = ST_IDLE;
            end
         end
         default: st_next = ST_IDLE;
      endcase

      // End-of-data acknowledge queues behind the last payload character
      if (code_go || stream_end) begin
         seq_buf_next[0] = code_char; // see (RL6), see (RL7)
         seq_buf_next[1] = station_id[15:8];
         seq_buf_next[2] = station_id[7:0];
         seq_buf_next[3] = HLTP_CMD_MSG;
         seq_buf_next[4] = HLTP_CH_CR;
         seq_buf_next[5] = HLTP_CH_LF;
         seq_len_next = code_cmd ? HLTP_SEQ_LONG : HLTP_SEQ_SHORT;
         seq_idx_next = 3'h0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < HLTP_SEQ_DEPTH; gi++) begin : g_seq
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               seq_buf_reg[gi] <= 8'h00;
            end else begin
               seq_buf_reg[gi] <= seq_buf_next[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_reg <= ST_IDLE;
         seq_len_reg <= 3'h0;
         seq_idx_reg <= 3'h0;
         tx_valid_reg <= 1'b0;
         tx_char_reg <= 8'h00;
         cnt_reg <= 6'h00;
         term_reg <= 1'b0;
         rcv_valid_reg <= 1'b0;
         rcv_char_reg <= 8'h00;
         rcv_kind_reg <= 2'h0;
         select_reg <= 1'b0;
         read_reg <= 1'b0;
         log_valid_reg <= 1'b0;
         log_dir_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         seq_len_reg <= seq_len_next;
         seq_idx_reg <= seq_idx_next;
         tx_valid_reg <= tx_valid_next;
         tx_char_reg <= tx_char_next;
         cnt_reg <= cnt_next;
         term_reg <= term_next;
         rcv_valid_reg <= rcv_valid_next;
         rcv_char_reg <= rcv_char_next;
         rcv_kind_reg <= rcv_kind_next;
         select_reg <= select_next;
         read_reg <= read_next;
         log_valid_reg <= log_valid_next;
         log_dir_reg <= log_dir_next;
      end
   end

   assign tx_valid = tx_valid_reg;
   assign tx_char = tx_char_reg;
   assign term_mode = term_reg;
   assign rcv_valid = rcv_valid_reg;
   assign rcv_char = rcv_char_reg;
   assign rcv_kind = rcv_kind_reg;
   assign program_select = select_reg;
   assign read_start = read_reg;
   assign log_valid = log_valid_reg;
   assign log_dir = log_dir_reg;
   assign busy = (st_reg != ST_IDLE) || !tx_idle;

endmodule : hltp_session

// file: shared/hltp_pkg.sv
package hltp_pkg;

   // Control characters of the session layer
   localparam logic [7:0] HLTP_CH_ENQ = 8'h05;
   localparam logic [7:0] HLTP_CH_ACK = 8'h06;
   localparam logic [7:0] HLTP_CH_EOT = 8'h04;
   localparam logic [7:0] HLTP_CH_CR = 8'h0d;
   localparam logic [7:0] HLTP_CH_LF = 8'h0a;

   // Command letters and the argument digit that follow an acknowledge
   localparam logic [7:0] HLTP_CMD_SELECT = 8'h43;
   localparam logic [7:0] HLTP_CMD_READ = 8'h52;
   localparam logic [7:0] HLTP_CMD_MSG = 8'h4d;
   localparam logic [7:0] HLTP_ARG_ONE = 8'h31;
   localparam logic [7:0] HLTP_ARG_NONE = 8'h00;
   localparam logic [7:0] HLTP_CH_UPPER_A = 8'h41;
   localparam logic [7:0] HLTP_CH_UPPER_Z = 8'h5a;
   localparam logic [7:0] HLTP_CH_DIGIT_0 = 8'h30;
   localparam logic [7:0] HLTP_CH_DIGIT_9 = 8'h39;

   // Longest message text, in characters
   localparam logic [5:0] HLTP_MSG_MAX = 6'h20;

   // Outgoing code sequence: code, two station digits, letter, CR, LF
   localparam int HLTP_SEQ_DEPTH = 6;
   localparam logic [2:0] HLTP_SEQ_SHORT = 3'h3;
   localparam logic [2:0] HLTP_SEQ_LONG = 3'h6;

   // Payload kinds presented on the receive port
   localparam logic [1:0] HLTP_RK_ID = 2'h0;
   localparam logic [1:0] HLTP_RK_MSG = 2'h1;

   // Log direction
   localparam logic HLTP_LOG_FROM_HOST = 1'b0;
   localparam logic HLTP_LOG_TO_HOST = 1'b1;

   typedef enum logic [1:0] {
      HLTP_K_ENQ,
      HLTP_K_ACK,
      HLTP_K_EOT
   } hltp_code_t;

   typedef enum logic [2:0] {
      PS_IDLE,
      PS_D1,
      PS_D2,
      PS_CMD,
      PS_ARG,
      PS_LF
   } hltp_parse_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WAIT_CMD,
      ST_RX_ID,
      ST_RX_MSG,
      ST_WAIT_EOT,
      ST_TX_DATA,
      ST_H_RACK,
      ST_CI_LINK,
      ST_CI_CMDACK,
      ST_CI_TEXT,
      ST_CI_RACK
   } hltp_state_t;

endpackage : hltp_pkg

// file: tb/hltp_host_model.sv
`timescale 1ns/1ns

module hltp_host_model
   import hltp_pkg::*;
(
   input wire logic clk,
   output logic rx_valid,
   output logic [7:0] rx_char,
   input wire logic tx_valid,
   input wire logic [7:0] tx_char,
   output logic tx_ready
);
   logic [7:0] out_q[$];
   logic [7:0] got[$];
   logic slow;
   logic [1:0] cnt;

   initial begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
      tx_ready = 1'b0;
      slow = 1'b0;
      cnt = 2'h0;
   end

   // One char per cycle; idle line toggles so stale data never looks valid
   always @(negedge clk) begin
      if (out_q.size() != 0) begin
         rx_valid <= 1'b1;
         rx_char <= out_q.pop_front();
      end else begin
         rx_valid <= 1'b0;
         rx_char <= ~rx_char;
      end
      cnt <= cnt + 2'h1;
      tx_ready <= tx_valid && (!slow || cnt == 2'h3);
   end

   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_char);
      end
   end
endmodule : hltp_host_model

// file: tb/hltp_session_props.sv
`timescale 1ns/1ns

module hltp_session_props
   import hltp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] station_id,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic tx_valid,
   input wire logic [7:0] tx_char,
   input wire logic tx_ready,
   input wire logic src_valid,
   input wire logic [7:0] src_char,
   input wire logic src_last,
   input wire logic src_ready,
   input wire logic msg_send_req,
   input wire logic lockout,
   input wire logic term_exit,
   input wire logic term_mode,
   input wire logic rcv_valid,
   input wire logic [7:0] rcv_char,
   input wire logic [1:0] rcv_kind,
   input wire logic program_select,
   input wire logic read_start,
   input wire logic log_valid,
   input wire logic log_dir,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic rd_reg;
   logic [5:0] nsrc_reg;
   logic room;
   // Host reads may run long; only own message text is capped
   always_ff @(posedge clk) begin
      rd_reg <= busy && (rd_reg || read_start);
      nsrc_reg <= !busy ? 6'h00 : nsrc_reg + {5'h00, src_valid && src_ready && room};
   end
   assign room = rd_reg || nsrc_reg != HLTP_MSG_MAX;

   sequence s_enq_ours;
      !busy && rx_valid && rx_char == HLTP_CH_ENQ ##1 rx_valid && rx_char == station_id[15:8]
         ##1 rx_valid && rx_char == station_id[7:0];
   endsequence
   sequence s_enq_other;
      !busy && rx_valid && rx_char == HLTP_CH_ENQ ##1 rx_valid && rx_char != station_id[15:8];
   endsequence

   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !tx_valid && !rcv_valid
      && !log_valid && !program_select && !read_start && !term_mode) else $error("reset");
   a_ack_reply: assert property (s_enq_ours |-> ##[1:4] tx_valid && tx_char == HLTP_CH_ACK)
      else $error("no enquiry answer");
   a_other_station: assert property (s_enq_other |=> !tx_valid [*6])
      else $error("answered other station");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("tx char dropped");
   a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("tx gap");
   a_src_to_tx: assert property (src_valid && src_ready && room |=> tx_valid
      && tx_char == $past(src_char)) else $error("payload not sent");
   a_text_limit: assert property (src_valid && src_ready && !room |=> !tx_valid)
      else $error("text past limit sent");
   // Parser and session each add one register stage
   a_rcv_echo: assert property (rcv_valid |-> $past(rx_valid, 2)
      && rcv_char == $past(rx_char, 2)) else $error("rcv char mismatch");
   a_term_entry: assert property ($rose(term_mode) |-> log_valid && log_dir == HLTP_LOG_FROM_HOST
      && !$past(lockout)) else $error("term entry");
   a_term_clear: assert property ($fell(term_mode) |-> $past(term_exit)) else $error("term clear");
   a_log_pulse: assert property (log_valid |=> !log_valid) else $error("log pulse");
   a_sel_pulse: assert property (program_select |=> !program_select) else $error("sel pulse");
   a_tx_busy: assert property (tx_valid |-> busy) else $error("tx while idle");
endmodule : hltp_session_props

bind hltp_session hltp_session_props hltp_session_props_inst (.clk, .rst_b, .station_id,
   .rx_valid, .rx_char, .tx_valid, .tx_char, .tx_ready, .src_valid, .src_char, .src_last,
   .src_ready, .msg_send_req, .lockout, .term_exit, .term_mode, .rcv_valid, .rcv_char,
   .rcv_kind, .program_select, .read_start, .log_valid, .log_dir, .busy);

// file: tb/hltp_session_tb.sv
`timescale 1ns/1ns

module hltp_session_tb;
   import hltp_pkg::*;
   localparam logic [15:0] SID = 16'h3031;
   logic clk, rst_b, rx_valid, tx_valid, tx_ready, src_valid, src_last, src_ready;
   logic msg_send_req, lockout, term_exit, term_mode, rcv_valid, program_select;
   logic read_start, log_valid, log_dir, busy;
   logic [7:0] rx_char, tx_char, src_char, rcv_char;
   logic [1:0] rcv_kind;
   int n_fail, n_compared, n_sel, n_rd;
   logic [31:0] seed;
   logic [7:0] ex_q[$];
   logic [7:0] txt[$];
   logic [9:0] rcv_q[$];
   logic log_q[$];

   hltp_session hltp_session_inst (.clk(clk), .rst_b(rst_b), .station_id(SID),
      .rx_valid(rx_valid), .rx_char(rx_char), .tx_valid(tx_valid), .tx_char(tx_char),
      .tx_ready(tx_ready), .src_valid(src_valid), .src_char(src_char), .src_last(src_last),
      .src_ready(src_ready), .msg_send_req(msg_send_req), .lockout(lockout),
      .term_exit(term_exit), .term_mode(term_mode), .rcv_valid(rcv_valid),
      .rcv_char(rcv_char), .rcv_kind(rcv_kind), .program_select(program_select),
      .read_start(read_start), .log_valid(log_valid), .log_dir(log_dir), .busy(busy));
   hltp_host_model host_inst (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char),
      .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rcv_valid) rcv_q.push_back({rcv_kind, rcv_char});
      if (log_valid) log_q.push_back(log_dir);
      if (program_select) n_sel++;
      if (read_start) n_rd++;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // DUT-bound chars go to the model, expected replies to ex_q
   function automatic void put(input logic [7:0] c, input bit to_dut);
      if (to_dut) host_inst.out_q.push_back(c);
      else ex_q.push_back(c);
   endfunction : put

   function automatic void put_code(input logic [7:0] c, input bit d);
      put(c, d);
      put(SID[15:8], d);
      put(SID[7:0], d);
   endfunction : put_code

   function automatic void put_cmd(input logic [7:0] l, input logic [7:0] a, input bit d);
      put_code(HLTP_CH_ACK, d);
      put(l, d);
      if (a != HLTP_ARG_NONE) put(a, d);
      put(HLTP_CH_CR, d);
      put(HLTP_CH_LF, d);
   endfunction : put_cmd

   function automatic void make_text(input int n, input bit d);
      txt.delete();
      for (int i = 0; i < n; i++) txt.push_back(HLTP_CH_UPPER_A + 8'(xs() % 26));
      foreach (txt[i]) put(txt[i], d);
   endfunction : make_text

   task automatic close_out();
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask : chk

   task automatic expect_tx();
      int g;
      for (g = 0; g < 800 && host_inst.got.size() < ex_q.size(); g++) @(negedge clk);
      if (g == 800) begin
         chk("tx count", ex_q.size(), host_inst.got.size());
         close_out();
      end
      foreach (ex_q[i]) chk("tx_char", ex_q[i], host_inst.got[i]);
      ex_q.delete();
      host_inst.got.delete();
   endtask : expect_tx

   task automatic wait_idle();
      int g;
      for (g = 0; g < 300 && (host_inst.out_q.size() != 0 || busy !== 1'b0); g++) @(negedge clk);
      chk("busy", 0, busy);
      if (g == 300) begin
         chk("idle wait", 0, g);
         close_out();
      end
   endtask : wait_idle

   task automatic feed();
      int i;
      i = 0;
      for (int g = 0; g < 2000 && i < txt.size(); g++) begin
         @(negedge clk);
         src_valid = 1'b1;
         src_char = txt[i];
         src_last = (i == txt.size() - 1);
         #1;
         if (src_ready === 1'b1) i++;
      end
      @(negedge clk);
      src_valid = 1'b0;
      src_last = 1'b0;
      src_char = ~src_char;
      chk("src taken", txt.size(), i);
      if (i < txt.size()) close_out();
   endtask : feed

   task automatic open_cmd(input logic [7:0] l, input logic [7:0] a);
      put_code(HLTP_CH_ENQ, 1);
      put_code(HLTP_CH_ACK, 0);
      expect_tx();
      put_cmd(l, a, 1);
      put_code(HLTP_CH_ACK, 0);
      expect_tx();
   endtask : open_cmd

   task automatic msg_in(input int n, input logic lock);
      lockout = lock;
      rcv_q.delete();
      log_q.delete();
      open_cmd(HLTP_CMD_MSG, HLTP_ARG_NONE);
      make_text(n, 1);
      put_code(HLTP_CH_ACK, 1);
      put_code(HLTP_CH_ACK, 0);
      expect_tx();
      chk("rcv count", (n > 32) ? 32 : n, rcv_q.size());
      foreach (rcv_q[i]) chk("rcv", {HLTP_RK_MSG, txt[i]}, rcv_q[i]);
      chk("log", {1'b1, HLTP_LOG_FROM_HOST}, {log_q.size() == 1, log_q[0]});
      chk("term_mode", !lock, term_mode);
      put_code(HLTP_CH_EOT, 1);
      wait_idle();
   endtask : msg_in

   task automatic read_sess(input int n, input logic s);
      n_rd = 0;
      host_inst.slow = s;
      open_cmd(HLTP_CMD_READ, HLTP_ARG_ONE);
      chk("read_start", 1, n_rd);
      make_text(n, 0);
      put_code(HLTP_CH_ACK, 0);
      feed();
      expect_tx();
      put_code(HLTP_CH_ACK, 1);
      put_code(HLTP_CH_EOT, 1);
      wait_idle();
   endtask : read_sess

   initial begin
      {rst_b, src_valid, src_last, msg_send_req, lockout, term_exit} = 6'h00;
      src_char = 8'h00;
      {n_fail, n_compared, n_sel, n_rd} = 0;
      seed = 32'h457b_43a0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      put(HLTP_CH_ENQ, 1);
      put(8'h31, 1);
      put(8'h32, 1);
      repeat (20) @(negedge clk);
      chk("stray reply", 0, host_inst.got.size());
      read_sess(4, 1'b0);
      rcv_q.delete();
      open_cmd(HLTP_CMD_SELECT, HLTP_ARG_ONE);
      make_text(6, 1);
      put_code(HLTP_CH_ACK, 1);
      put_code(HLTP_CH_ACK, 0);
      expect_tx();
      chk("select", 1, n_sel);
      chk("id count", txt.size(), rcv_q.size());
      foreach (rcv_q[i]) chk("id", {HLTP_RK_ID, txt[i]}, rcv_q[i]);
      put_code(HLTP_CH_EOT, 1);
      wait_idle();
      read_sess(7, 1'b1);
      msg_in(34, 1'b0);
      term_exit = 1'b1;
      @(negedge clk);
      term_exit = 1'b0;
      @(negedge clk);
      chk("term_mode", 0, term_mode);
      msg_in(5, 1'b1);
      log_q.delete();
      msg_send_req = 1'b1;
      @(negedge clk);
      msg_send_req = 1'b0;
      put_code(HLTP_CH_ENQ, 0);
      expect_tx();
      put_code(HLTP_CH_ACK, 1);
      put_cmd(HLTP_CMD_MSG, HLTP_ARG_NONE, 0);
      expect_tx();
      put_code(HLTP_CH_ACK, 1);
      make_text(34, 0);
      // Text beyond the limit is taken from the source but never sent
      repeat (2) void'(ex_q.pop_back());
      put_code(HLTP_CH_ACK, 0);
      feed();
      expect_tx();
      put_code(HLTP_CH_ACK, 1);
      put_code(HLTP_CH_EOT, 0);
      expect_tx();
      chk("log", {1'b1, HLTP_LOG_TO_HOST}, {log_q.size() == 1, log_q[0]});
      wait_idle();
      close_out();
   end
endmodule : hltp_session_tb
